// ==== sar_params.svh ====
// Constants for the serial converter readout block
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define DATA_BITS 12
`define ACQ_EDGES 2
`define NULL_EDGES 1
`define LAST_COUNT 6'd36
`define SYNC_STAGES 2
`endif

// ==== sar_pkg.sv ====
// Types shared by the serial converter readout block
package sar_pkg;
    typedef enum logic [2:0] {
        st_sleep, st_acquire, st_null, st_msb, st_lsb, st_done
    } phase_e;
    typedef logic [11:0] word_t;
endpackage

// ==== sar_edge_if.sv ====
// Edge events of the host bit clock and select
`timescale 1ns/1ps
interface sar_edge_if;
    logic clk_fall;
    logic clk_rise;
    logic sel_fall;
    logic sel_high;
    modport src (output clk_fall, output clk_rise, output sel_fall, output sel_high);
    modport dst (input clk_fall, input clk_rise, input sel_fall, input sel_high);
endinterface

// ==== sar_edge_detect.sv ====
// Edge detector for bit clock and select pins
`timescale 1ns/1ps
`include "sar_params.svh"
module sar_edge_detect (
    // System
    input wire logic clock,
    input wire logic rst,
    // Pins
    input wire logic bit_clock,
    input wire logic select_or_sleep_n,
    // Events
    sar_edge_if.src ev
);
    logic clk_q;
    logic sel_q;

    // Previous pin levels for edge detection
    always_ff @(posedge clock) begin
        if (rst) begin
            clk_q <= 1'b0;
            sel_q <= 1'b1;
        end else begin
            clk_q <= bit_clock;
            sel_q <= select_or_sleep_n;
        end
    end

    assign ev.clk_fall = clk_q & ~bit_clock;
    assign ev.clk_rise = ~clk_q & bit_clock;
    assign ev.sel_fall = sel_q & ~select_or_sleep_n;
    assign ev.sel_high = select_or_sleep_n;
endmodule

// ==== sar_adc_serial_readout.sv ====
// Serial readout logic of a 12-bit successive-approximation converter
`timescale 1ns/1ps
`include "sar_params.svh"
module sar_adc_serial_readout
    import sar_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic rst,
    // Host serial link
    input wire logic bit_clock,
    input wire logic select_or_sleep_n,
    output logic result_out,
    output logic result_oe,
    // Analog front end
    input wire word_t sample_code,
    output logic sampling,
    output logic powered
);
    sar_edge_if ev ();
    phase_e phase;
    logic [5:0] edges;
    logic [3:0] bit_idx;
    word_t result;

    sar_edge_detect u_edges (
        .clock(clock),
        .rst(rst),
        .bit_clock(bit_clock),
        .select_or_sleep_n(select_or_sleep_n),
        .ev(ev)
    );

    // Sequence of the transfer, one step per falling bit clock edge
    always_ff @(posedge clock) begin
        if (rst) begin
            phase <= st_sleep;
            edges <= 6'h00;
            bit_idx <= 4'h0;
        end else if (ev.sel_high) begin
            phase <= st_sleep;
            edges <= 6'h00;
            bit_idx <= 4'h0;
        end else if (ev.sel_fall) begin
            phase <= st_acquire;
            edges <= 6'h00;
            bit_idx <= 4'h0;
        end else if (ev.clk_fall) begin
            unique case (phase)
                st_sleep: begin
                    phase <= st_sleep;
                end
                st_acquire: begin
                    // acquisition spans the first two falls
                    edges <= edges + 6'h01;
                    if (edges == 6'(`ACQ_EDGES - 1)) begin
                        phase <= st_null;
                    end
                end
                st_null: begin
                    phase <= st_msb;
                    bit_idx <= 4'(`DATA_BITS - 2);
                end
                st_msb: begin
                    if (bit_idx == 4'h0) begin
                        phase <= st_lsb;
                        bit_idx <= 4'h1;
                    end else begin
                        bit_idx <= bit_idx - 4'h1;
                    end
                end
                st_lsb: begin
                    // stop after the top bit repeats
                    // Index runs one past the top bit so that bit keeps a full period
                    if (bit_idx == 4'(`DATA_BITS)) begin
                        phase <= st_done;
                    end else begin
                        bit_idx <= bit_idx + 4'h1;
                    end
                end
                st_done: begin
                    phase <= st_done;
                end
            endcase
        end
    end

    // result of the conversion in progress, captured as acquisition ends
    always_ff @(posedge clock) begin
        if (rst) begin
            result <= 12'h000;
        end else if (ev.clk_fall && phase == st_acquire && edges == 6'(`ACQ_EDGES - 1)) begin
            result <= sample_code;
        end
    end

    // drive bits registered from each falling edge
    always_ff @(posedge clock) begin
        if (rst || ev.sel_high) begin
            result_out <= 1'b0;
            result_oe <= 1'b0;
        end else if (ev.clk_fall) begin
            unique case (phase)
                st_acquire: begin
                    // enable at second pulse, null bit low
                    result_oe <= (edges == 6'(`ACQ_EDGES - 1));
                    result_out <= 1'b0;
                end
                st_null: begin
                    result_oe <= 1'b1;
                    result_out <= result[`DATA_BITS - 1];
                end
                st_msb: begin
                    // walk down from the bit below the top
                    result_oe <= 1'b1;
                    result_out <= result[bit_idx];
                end
                st_lsb: begin
                    // LSB-first repeat, float after top bit
                    if (bit_idx == 4'(`DATA_BITS)) begin
                        result_oe <= 1'b0;
                        result_out <= 1'b0;
                    end else begin
                        // Bottom bit is shared by both passes, so the repeat starts at bit 1
                        result_oe <= 1'b1;
                        result_out <= result[bit_idx];
                    end
                end
                default: begin
                    result_oe <= 1'b0;
                    result_out <= 1'b0;
                end
            endcase
        end
    end

    // power state and sampling window for the analog side
    always_ff @(posedge clock) begin
        if (rst) begin
            powered <= 1'b0;
            sampling <= 1'b0;
        end else begin
            powered <= ~select_or_sleep_n;
            sampling <= ~select_or_sleep_n && (ev.sel_fall || phase == st_acquire);
        end
    end

    chk_early_drive: assert property (@(posedge clock) disable iff (rst)
        (phase == st_acquire && edges == 6'h00) |=> !result_oe)
        else $error("output driven too early");

    sequence sel_up;
        ev.sel_high;
    endsequence
    chk_sleep_float: assert property (@(posedge clock) disable iff (rst)
        sel_up |=> !result_oe)
        else $error("output driven while deselected");

    chk_done_float: assert property (@(posedge clock) disable iff (rst)
        (phase == st_done) |-> !result_oe)
        else $error("output driven after transfer end");

    chk_null_low: assert property (@(posedge clock) disable iff (rst)
        (phase == st_null && result_oe) |-> !result_out)
        else $error("null bit not low");

    chk_start_fall: assert property (@(posedge clock) disable iff (rst)
        ev.sel_fall |=> phase == st_acquire)
        else $error("select fall did not start");

    chk_power_sel: assert property (@(posedge clock) disable iff (rst)
        select_or_sleep_n |=> !powered)
        else $error("powered while deselected");

    // MSB appears after the null bit
    chk_msb_first: assert property (@(posedge clock) disable iff (rst)
        (ev.clk_fall && phase == st_null && !ev.sel_high && !ev.sel_fall)
        |=> result_out == result[11])
        else $error("first data bit not MSB");

    chk_no_restart: assert property (@(posedge clock) disable iff (rst)
        (phase == st_done && !ev.sel_high && !ev.sel_fall) |=> phase == st_done)
        else $error("restart without select toggle");

    // Second fall with select held low ends acquisition
    sequence null_entry;
        ev.clk_fall && !ev.sel_high && !ev.sel_fall && phase == st_acquire
            && edges == 6'(`ACQ_EDGES - 1);
    endsequence
    // driver turns on with the null bit
    chk_null_enable: assert property (@(posedge clock) disable iff (rst)
        null_entry |=> result_oe && !result_out)
        else $error("driver not enabled at second fall");

    // Fall after the repeated top bit, select still low
    sequence top_bit_gone;
        ev.clk_fall && !ev.sel_high && !ev.sel_fall && phase == st_lsb
            && bit_idx == 4'(`DATA_BITS);
    endsequence
    // float and stop after the repeated top bit
    chk_top_float: assert property (@(posedge clock) disable iff (rst)
        top_bit_gone |=> !result_oe && phase == st_done)
        else $error("driver still on after repeated top bit");
endmodule

// ==== sar_host_model.sv ====
// Behavioural host that clocks frames and records the returned bits
`timescale 1ns/1ps
module sar_host_model (
    // System
    input wire logic clock,
    // Serial link
    output logic bit_clock,
    output logic select_or_sleep_n,
    input wire logic result_out,
    input wire logic result_oe,
    input wire logic sampling
);
    logic cap_out [0:31];
    logic cap_oe [0:31];
    logic cap_smp [0:31];
    // Idle deselected, clock stands still low between frames
    initial begin
        bit_clock = 1'b0;
        select_or_sleep_n = 1'b1;
    end
    // select falls, then falls paced by half
    task automatic frame(input int falls, input int half);
        @(posedge clock);
        select_or_sleep_n <= 1'b0;
        for (int k = 1; k <= falls; k++) begin
            repeat (half) @(posedge clock);
            bit_clock <= 1'b1;
            repeat (half) @(posedge clock);
            bit_clock <= 1'b0;
            repeat (half) @(posedge clock);
            // Sampled midway through the low phase, long after the bit settled
            #1;
            cap_out[k] = result_out;
            cap_oe[k] = result_oe;
            cap_smp[k] = sampling;
        end
        @(posedge clock);
        select_or_sleep_n <= 1'b1;
    endtask
endmodule

// ==== sar_adc_serial_readout_test.sv ====
// Self-checking bench for the serial converter readout
`timescale 1ns/1ps
module sar_adc_serial_readout_test;
    import sar_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    word_t sample_code = 12'h000;
    logic bit_clock, select_or_sleep_n, result_out, result_oe, sampling, powered;
    int miscompares = 0;
    int total_checks = 0;
    // 100 MHz clock
    always #5 clock = ~clock;
    sar_adc_serial_readout i_sar_adc_serial_readout (.clock(clock), .rst(rst),
        .bit_clock(bit_clock), .select_or_sleep_n(select_or_sleep_n),
        .result_out(result_out), .result_oe(result_oe), .sample_code(sample_code),
        .sampling(sampling), .powered(powered));
    sar_host_model i_sar_host_model (.clock(clock), .bit_clock(bit_clock),
        .select_or_sleep_n(select_or_sleep_n), .result_out(result_out),
        .result_oe(result_oe), .sampling(sampling));
    // Single comparison point
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Judge one recorded frame against the code taken at acquisition
    task automatic check_frame(input word_t code, input int falls);
        logic [11:0] msb, lsb;
        logic [23:0] oe_run;
        for (int k = 2; k <= 25; k++) oe_run[k - 2] = i_sar_host_model.cap_oe[k];
        for (int k = 3; k <= 14; k++) msb[14 - k] = i_sar_host_model.cap_out[k];
        for (int k = 14; k <= 25; k++) lsb[k - 14] = i_sar_host_model.cap_out[k];
        check("oe after fall 1", i_sar_host_model.cap_oe[1], 1'b0);
        check("sampling fall 1", i_sar_host_model.cap_smp[1], 1'b1);
        check("sampling fall 3", i_sar_host_model.cap_smp[3], 1'b0);
        check("null bit", i_sar_host_model.cap_out[2], 1'b0);
        check("oe falls 2..25", oe_run, 24'hffffff);
        check("msb first word", msb, code);
        check("lsb first word", lsb, code);
        for (int k = 26; k <= falls; k++) check("oe after end", i_sar_host_model.cap_oe[k], 1'b0);
    endtask
    // Deselected state seen a few cycles after select rises
    task automatic check_sleep();
        repeat (6) @(posedge clock);
        #1;
        check("powered asleep", powered, 1'b0);
        check("oe asleep", result_oe, 1'b0);
    endtask
    task automatic test_full();
        sample_code <= 12'ha5c;
        fork
            i_sar_host_model.frame(30, 11);
            begin
                repeat (40) @(posedge clock);
                #1;
                check("powered in frame", powered, 1'b1);
            end
        join
        check_frame(12'ha5c, 30);
        check_sleep();
        $display("test_full done");
    endtask
    // Slow clock, code changes after capture; result must not follow it
    task automatic test_slow_change();
        sample_code <= 12'h3c1;
        fork
            i_sar_host_model.frame(27, 40);
            begin
                repeat (400) @(posedge clock);
                sample_code <= 12'hfff;
            end
        join
        check_frame(12'h3c1, 27);
        check_sleep();
        $display("test_slow_change done");
    endtask
    // Abort mid-word, then a clean restart
    task automatic test_abort();
        sample_code <= 12'h801;
        i_sar_host_model.frame(8, 11);
        check_sleep();
        i_sar_host_model.frame(28, 11);
        check_frame(12'h801, 28);
        $display("test_abort done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        check("powered at idle", powered, 1'b0);
        test_full();
        test_slow_change();
        test_abort();
        print_verdict();
    end
    // Watchdog, nearly four times the expected run
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
endmodule
